// file: shared/cfs_pkg.sv
package cfs_pkg;

	// ==========================================
	// register map (byte addresses)
	localparam logic [11:0] ADDR_RETRY = 12'h000;
	localparam logic [11:0] ADDR_TIMEOUT = 12'h004;
	localparam logic [11:0] ADDR_STOPMODE = 12'h008;
	localparam logic [11:0] ADDR_USERGRP = 12'h00C;
	localparam logic [11:0] ADDR_TERMSEL = 12'h010;
	localparam logic [11:0] ADDR_CTRL = 12'h014;
	localparam logic [11:0] ADDR_STATUS = 12'h018;
	localparam logic [11:0] ADDR_HIST = 12'h01C;
	localparam logic [11:0] ADDR_DISP = 12'h020;

	// ==========================================
	// setting encodings and reset values
	localparam logic [13:0] SET_DISABLED = 14'h270F;
	localparam logic [13:0] RETRY_RST = 14'h0001;
	localparam logic [13:0] TIMEOUT_RST = 14'h0000;
	localparam logic [13:0] TIMEOUT_MAX = 14'h270E;
	localparam logic [1:0] STOPMODE_RST = 2'h0;
	localparam logic [7:0] TERMSEL_RST = 8'h00;
	localparam logic [7:0] TERM_ALARM_HI = 8'h62;
	localparam logic [7:0] TERM_ALARM_LO = 8'hC6;
	localparam logic [7:0] TRIP_CODE = 8'hA1;
	localparam logic [7:0] NO_CODE = 8'h00;

	// ==========================================
	// control and status bit positions
	localparam int CTRL_CLR = 0;
	localparam int ST_TRIP = 0;
	localparam int ST_ALARM = 1;
	localparam int ST_FAULT = 2;
	localparam int ST_ARMED = 3;
	localparam int ST_DECEL = 4;

	// ==========================================
	// timing: one timeout unit is 0.1 s
	localparam int CLK_HZ = 25000000;
	localparam int UNIT_MS = 100;
	localparam int UNIT_CYC = CLK_HZ / 1000 * UNIT_MS;

	// stop behaviour
	typedef enum logic [1:0] {
		CFS_COAST = 2'h0,
		CFS_DECEL_ALM = 2'h1,
		CFS_DECEL_RESTART = 2'h2,
		CFS_COAST_ALT = 2'h3
	} cfs_mode_e;

	typedef enum logic [1:0] {
		CFS_RUN = 2'b00,
		CFS_DECEL = 2'b01,
		CFS_STOPPED = 2'b11
	} cfs_state_e;

endpackage : cfs_pkg

// file: rtl/cfs_supervisor.sv
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module cfs_supervisor
	import cfs_pkg::*;
(
	// clock and reset
	input wire logic I_CLK,
	input wire logic I_RESET,
	// apb slave
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [11:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	output logic [31:0] O_PRDATA,
	output logic O_PREADY,
	output logic O_PSLVERR,
	// link receiver events
	input wire logic I_MSG_OK,
	input wire logic I_MSG_ERR,
	input wire logic I_MODBUS_SEL,
	input wire logic I_NET_MODE,
	input wire logic I_OPTION_FITTED,
	// drive side
	input wire logic I_HARD_RESET,
	input wire logic I_MOTOR_STOPPED,
	input wire logic I_RUN_CMD,
	input wire logic [15:0] I_SPEED_CMD,
	// drive outputs
	output logic O_COAST,
	output logic O_DECEL,
	output logic O_RUN,
	output logic [15:0] O_SPEED,
	output logic O_FAULT_OUTPUT_SIGNAL,
	output logic O_ALARM_TERMINAL,
	output logic [7:0] O_DISPLAY_CODE
);

	// ==========================================
	// settings
	logic [13:0] retry_q;
	logic [13:0] timeout_q;
	logic [1:0] mode_q;
	logic [7:0] usergrp_q;
	logic [7:0] termsel_q;
	logic [7:0] hist_q;
	logic [13:0] err_cnt_q;
	logic [13:0] units_q;
	logic [31:0] tick_q;
	logic armed_q;
	logic net_q;
	logic trip_q;
	logic alarm_q;
	logic fault_q;
	logic held_run_q;
	logic [15:0] held_speed_q;
	cfs_state_e state_q;

	logic wr_en;
	logic set_ok;
	logic clr_req;
	logic msg_any;
	logic retry_trip;
	logic loss_trip;
	logic net_trip;
	logic trip_evt;
	logic mapped;
	logic fault_cond;

	// decode a register address to its mapped flag
	function automatic logic is_mapped(input logic [11:0] a);
		is_mapped = (a == ADDR_RETRY) || (a == ADDR_TIMEOUT) || (a == ADDR_STOPMODE) ||
			(a == ADDR_USERGRP) || (a == ADDR_TERMSEL) || (a == ADDR_CTRL) ||
			(a == ADDR_STATUS) || (a == ADDR_HIST) || (a == ADDR_DISP);
	endfunction : is_mapped

	// apb access phase strobes; zero wait states
	assign mapped = is_mapped(I_PADDR);
	assign wr_en = I_PSEL && I_PENABLE && I_PWRITE && mapped;
	assign O_PREADY = 1'b1;
	// unmapped access answers with slave error and has no side effect
	assign O_PSLVERR = I_PSEL && I_PENABLE && !mapped;
	assign set_ok = (usergrp_q == 8'h00) || I_OPTION_FITTED;
	assign clr_req = wr_en && (I_PADDR == ADDR_CTRL) && I_PWDATA[CTRL_CLR];
	assign msg_any = I_MSG_OK || I_MSG_ERR;

	// ==========================================
	// settings writes, guarded by the group select
	// a refused write is dropped silently; the bus transfer still completes
	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			retry_q <= RETRY_RST;
			timeout_q <= TIMEOUT_RST;
			mode_q <= STOPMODE_RST;
		end else if (wr_en && set_ok) begin
			if (I_PADDR == ADDR_RETRY) begin
				retry_q <= I_PWDATA[13:0];
			end
			if (I_PADDR == ADDR_TIMEOUT) begin
				timeout_q <= I_PWDATA[13:0];
			end
			if (I_PADDR == ADDR_STOPMODE) begin
				mode_q <= I_PWDATA[1:0];
			end
		end
	end

	// group select and terminal function are always writable
	// the select itself never locks, or the settings could not be reopened
	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			usergrp_q <= 8'h00;
			termsel_q <= TERMSEL_RST;
		end else if (wr_en) begin
			if (I_PADDR == ADDR_USERGRP) begin
				usergrp_q <= I_PWDATA[7:0];
			end
			if (I_PADDR == ADDR_TERMSEL) begin
				termsel_q <= I_PWDATA[7:0];
			end
		end
	end

	// ==========================================
	// consecutive receive error counting
	// saturates so a flood of errors cannot wrap back under the limit
	// modbus error frames leave the count untouched; a good message clears it
	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			err_cnt_q <= 14'h0000;
		end else if (I_MSG_OK) begin
			err_cnt_q <= 14'h0000;
		end else if (I_MSG_ERR && !I_MODBUS_SEL && err_cnt_q != 14'h3FFF) begin
			err_cnt_q <= err_cnt_q + 14'h0001;
		end
	end

	// trip once the count exceeds the limit, never with the disabled code
	// a clean message in the same cycle wins, else the stale count would
	// re-trip at the very edge that should release a mode 2 restart
	assign retry_trip = !I_MODBUS_SEL && !I_MSG_OK && retry_q != SET_DISABLED &&
		err_cnt_q > retry_q;

	// alarm flag: set by errors in disabled mode; set wins over clear
	// an error and a clear in one cycle leave the flag set
	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			alarm_q <= 1'b0;
		end else if (I_MSG_ERR && !I_MODBUS_SEL && retry_q == SET_DISABLED) begin
			alarm_q <= 1'b1;
		end else if (clr_req || I_MSG_OK) begin
			alarm_q <= 1'b0;
		end
	end

	// terminal routing with selectable polarity
	// an unassigned terminal rests low
	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			O_ALARM_TERMINAL <= 1'b0;
		end else if (termsel_q == TERM_ALARM_HI) begin
			O_ALARM_TERMINAL <= alarm_q;
		end else if (termsel_q == TERM_ALARM_LO) begin
			O_ALARM_TERMINAL <= !alarm_q;
		end else begin
			O_ALARM_TERMINAL <= 1'b0;
		end
	end

	// ==========================================
	// signal loss supervision
	// registered mode level; its rising edge marks mode entry
	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			net_q <= 1'b0;
		end else begin
			net_q <= I_NET_MODE;
		end
	end

	// arm at the first message inside network mode
	always_ff @(posedge I_CLK) begin
		if (I_RESET || !I_NET_MODE) begin
			armed_q <= 1'b0;
		end else if (msg_any) begin
			armed_q <= 1'b1;
		end
	end

	// 0.1 s tick and unit counter; any message restarts both
	// one shared unit counter: resolution is one unit, traded for area
	// the 32-bit tick leaves ample room for the 0.1 s count
	always_ff @(posedge I_CLK) begin
		if (I_RESET || !armed_q || msg_any) begin
			tick_q <= 32'h0000_0000;
			units_q <= 14'h0000;
		end else if (tick_q == 32'(UNIT_CYC - 1)) begin
			tick_q <= 32'h0000_0000;
			if (units_q != 14'h3FFF) begin
				units_q <= units_q + 14'h0001;
			end
		end else begin
			tick_q <= tick_q + 32'h0000_0001;
		end
	end

	// host must keep traffic denser than the interval
	// a message in this cycle wins over the elapsed count
	assign loss_trip = armed_q && !msg_any && timeout_q != SET_DISABLED &&
		timeout_q != 14'h0000 && timeout_q <= TIMEOUT_MAX && units_q >= timeout_q;
	// timeout 0 trips on mode entry even while traffic flows
	assign net_trip = I_NET_MODE && !net_q && timeout_q == 14'h0000;
	assign trip_evt = retry_trip || loss_trip || net_trip;

	// ==========================================
	// fault condition: latched trip, cleared by software
	// in modes 0/1/3 the trip holds; in mode 2 it drops when the cause goes
	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			trip_q <= 1'b0;
		end else if (trip_evt) begin
			trip_q <= 1'b1;
		end else if (clr_req || (mode_q == CFS_DECEL_RESTART && I_MSG_OK)) begin
			trip_q <= 1'b0;
		end
	end
	assign fault_cond = trip_q || trip_evt;

	// ==========================================
	// stop sequencing
	// decel ends early when the cause clears; the ramps themselves are external
	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			state_q <= CFS_RUN;
		end else begin
			unique case (state_q)
				CFS_RUN: begin
					if (fault_cond) begin
						if (mode_q == CFS_COAST || mode_q == CFS_COAST_ALT) begin
							state_q <= CFS_STOPPED;
						end else begin
							state_q <= CFS_DECEL;
						end
					end
				end
				CFS_DECEL: begin
					if (!fault_cond) begin
						state_q <= CFS_RUN;
					end else if (I_MOTOR_STOPPED) begin
						state_q <= CFS_STOPPED;
					end
				end
				CFS_STOPPED: begin
					if (!fault_cond) begin
						state_q <= CFS_RUN;
					end
				end
				// an unused code parks the drive stopped until cleared
				default: begin
					state_q <= CFS_STOPPED;
				end
			endcase
		end
	end

	// fault output: immediate in coast, after stop in mode 1, never in mode 2
	// mode 2 keeps the output low, so its faults never reach the history
	always_ff @(posedge I_CLK) begin
		if (I_RESET || !fault_cond) begin
			fault_q <= 1'b0;
		end else if (mode_q == CFS_COAST || mode_q == CFS_COAST_ALT) begin
			fault_q <= 1'b1;
		end else if (mode_q == CFS_DECEL_ALM && state_q == CFS_STOPPED) begin
			fault_q <= 1'b1;
		end
	end

	// history stores the code only on a real fault output
	// hardware write only; software cannot erase the record
	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			hist_q <= NO_CODE;
		end else if (fault_q) begin
			hist_q <= TRIP_CODE;
		end
	end

	// commands held from before the fault: run is replayed on restart, speed is driven during decel and stop
	// sampled only while running clean, so a fault freezes the last command
	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			held_run_q <= 1'b0;
			held_speed_q <= 16'h0000;
		end else if (state_q == CFS_RUN && !fault_cond) begin
			held_run_q <= I_RUN_CMD;
			held_speed_q <= I_SPEED_CMD;
		end
	end

	// ==========================================
	// drive outputs; decel and accel ramps belong to the ramp generator
	// hard reset overrides every stop mode and forces a coast
	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			O_COAST <= 1'b1;
			O_DECEL <= 1'b0;
			O_RUN <= 1'b0;
			O_SPEED <= 16'h0000;
			O_FAULT_OUTPUT_SIGNAL <= 1'b0;
			O_DISPLAY_CODE <= NO_CODE;
		end else begin
			O_COAST <= I_HARD_RESET || (state_q == CFS_STOPPED && mode_q != CFS_DECEL_ALM
				&& mode_q != CFS_DECEL_RESTART);
			O_DECEL <= !I_HARD_RESET && state_q == CFS_DECEL;
			O_RUN <= !I_HARD_RESET && state_q == CFS_RUN && !fault_cond &&
				(held_run_q || I_RUN_CMD);
			O_SPEED <= (state_q == CFS_RUN) ? I_SPEED_CMD : held_speed_q;
			O_FAULT_OUTPUT_SIGNAL <= fault_q;
			// code shown while faulted, monitor afterwards
			// modes 1 and 2 wait for standstill before showing the code
			if (fault_cond && (mode_q != CFS_DECEL_ALM || state_q == CFS_STOPPED)) begin
				O_DISPLAY_CODE <= (mode_q == CFS_DECEL_RESTART && state_q != CFS_STOPPED)
					? NO_CODE : TRIP_CODE;
			end else begin
				O_DISPLAY_CODE <= NO_CODE;
			end
		end
	end

	// ==========================================
	// read mux; history view shows temporary code without storing it
	// loaded in the setup cycle so the data stands through the access phase
	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			O_PRDATA <= 32'h0000_0000;
		end else if (I_PSEL && !I_PENABLE && !I_PWRITE) begin
			unique case (I_PADDR)
				ADDR_RETRY: O_PRDATA <= {18'h0_0000, retry_q};
				ADDR_TIMEOUT: O_PRDATA <= {18'h0_0000, timeout_q};
				ADDR_STOPMODE: O_PRDATA <= {30'h0000_0000, mode_q};
				ADDR_USERGRP: O_PRDATA <= {24'h00_0000, usergrp_q};
				ADDR_TERMSEL: O_PRDATA <= {24'h00_0000, termsel_q};
				ADDR_STATUS: O_PRDATA <= {27'h000_0000, state_q == CFS_DECEL, armed_q,
					fault_q, alarm_q, trip_q};
				ADDR_HIST: O_PRDATA <= {24'h00_0000,
					(fault_cond && !fault_q && mode_q == CFS_DECEL_RESTART) ? TRIP_CODE
					: hist_q};
				ADDR_DISP: O_PRDATA <= {24'h00_0000, O_DISPLAY_CODE};
				default: O_PRDATA <= 32'h0000_0000;
			endcase
		end
	end

	// nothing here transmits; replies are the protocol engine's job

endmodule : cfs_supervisor
`default_nettype wire

// file: verification/cfs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module cfs_monitor
	import cfs_pkg::*;
(
	// clock and reset
	input wire logic I_CLK,
	input wire logic I_RESET,
	// apb side
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [11:0] I_PADDR,
	input wire logic [31:0] O_PRDATA,
	input wire logic O_PSLVERR,
	// drive side
	input wire logic I_HARD_RESET,
	input wire logic O_COAST,
	input wire logic O_DECEL,
	input wire logic O_RUN,
	input wire logic O_FAULT_OUTPUT_SIGNAL,
	input wire logic [7:0] O_DISPLAY_CODE
);
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (I_RESET);

	// ==========================================
	// bus answers
	AST_ERR_PHASE: assert property (O_PSLVERR |-> I_PSEL && I_PENABLE)
		else $error("slave error outside access");
	AST_ERR_MAPPED: assert property (I_PSEL && I_PADDR[1:0] == 2'h0 && I_PADDR <= ADDR_DISP |-> !O_PSLVERR)
		else $error("slave error on mapped word");
	AST_UNMAPPED_ZERO: assert property (O_PSLVERR && !I_PWRITE |-> O_PRDATA == 32'h0)
		else $error("unmapped read not zero");

	// ==========================================
	// stop behaviour; reset edge sees values held from reset
	AST_RESET_VALUES: assert property ($fell(I_RESET) |-> O_COAST && !O_RUN && !O_FAULT_OUTPUT_SIGNAL)
		else $error("outputs wrong after reset");
	AST_HARD_COAST: assert property (I_HARD_RESET |-> ##[1:2] O_COAST)
		else $error("no coast on hard reset");
	AST_FAULT_NORUN: assert property (O_FAULT_OUTPUT_SIGNAL |-> !O_RUN)
		else $error("running with fault output");
	AST_DECEL_NOFAULT: assert property ($rose(O_DECEL) |-> !O_FAULT_OUTPUT_SIGNAL)
		else $error("fault output at decel start");
	AST_FAULT_DISPLAY: assert property ($rose(O_FAULT_OUTPUT_SIGNAL) |-> ##[0:2] O_DISPLAY_CODE == TRIP_CODE)
		else $error("fault output without trip code");
endmodule : cfs_monitor

bind cfs_supervisor cfs_monitor i_cfs_monitor (.I_CLK, .I_RESET, .I_PSEL, .I_PENABLE, .I_PWRITE,
	.I_PADDR, .O_PRDATA, .O_PSLVERR, .I_HARD_RESET, .O_COAST, .O_DECEL, .O_RUN,
	.O_FAULT_OUTPUT_SIGNAL, .O_DISPLAY_CODE);
`default_nettype wire

// file: verification/cfs_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module cfs_host_model (
	// clock
	input wire logic i_clk,
	// message events
	output logic o_msg_ok,
	output logic o_msg_err
);
	// quiet line until the host asks
	initial begin
		o_msg_ok = 1'h0;
		o_msg_err = 1'h0;
	end

	// one message, gap sets how slowly the host follows up
	task automatic send(input logic bad, input int gap);
		@(posedge i_clk);
		o_msg_ok <= !bad;
		o_msg_err <= bad;
		@(posedge i_clk);
		o_msg_ok <= 1'h0;
		o_msg_err <= 1'h0;
		repeat (gap) @(posedge i_clk);
	endtask : send
endmodule : cfs_host_model
`default_nettype wire

// file: verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	import cfs_pkg::*;
	// ==========================================
	// signals
	logic clk = 1'h0, rst = 1'h1, psel = 1'h0, pen = 1'h0, pwr = 1'h0, se;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, ok, err, modbus = 1'h0, net = 1'h0, opt = 1'h0, hrst = 1'h0;
	logic stopd = 1'h0, run = 1'h0, coast, decel, o_run, fout, aterm;
	logic [15:0] spd = 16'h0, o_spd;
	logic [7:0] disp;
	int fails = 0, n_checks = 0;

	// free running clock
	always #20 clk = ~clk;

	cfs_host_model u_host (.i_clk(clk), .o_msg_ok(ok), .o_msg_err(err));
	cfs_supervisor i_cfs_supervisor (.I_CLK(clk), .I_RESET(rst), .I_PSEL(psel),
		.I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
		.O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_MSG_OK(ok),
		.I_MSG_ERR(err), .I_MODBUS_SEL(modbus), .I_NET_MODE(net), .I_OPTION_FITTED(opt),
		.I_HARD_RESET(hrst), .I_MOTOR_STOPPED(stopd), .I_RUN_CMD(run), .I_SPEED_CMD(spd),
		.O_COAST(coast), .O_DECEL(decel), .O_RUN(o_run), .O_SPEED(o_spd),
		.O_FAULT_OUTPUT_SIGNAL(fout), .O_ALARM_TERMINAL(aterm), .O_DISPLAY_CODE(disp));

	// ==========================================
	// checking and closing
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : end_sim

	// apb transfer; waits bounded, a missing pready ends the run
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'h1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'h1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		if (pready !== 1'h1) begin
			fails++;
			end_sim();
		end
		rd = prdata;
		se = pslverr;
		psel <= 1'h0;
		pen <= 1'h0;
	endtask : apb

	// ==========================================
	// scenarios
	task automatic t_reset();
		logic [11:0] ad [4] = '{ADDR_RETRY, ADDR_TIMEOUT, ADDR_STOPMODE, ADDR_TERMSEL};
		logic [31:0] ex [4] = '{RETRY_RST, TIMEOUT_RST, STOPMODE_RST, TERMSEL_RST};
		chk("coast", coast, 1'h1);
		for (int i = 0; i < 4; i++) begin
			apb(1'h0, ad[i], 32'h0);
			chk("reset value", rd, ex[i]);
		end
		apb(1'h0, 12'h024, 32'h0);
		chk("unmapped err", se, 1'h1);
		chk("unmapped data", rd, 32'h0);
	endtask : t_reset

	// a good message in between restarts the error count
	task automatic t_retry();
		u_host.send(1'h1, 0);
		u_host.send(1'h0, 0);
		u_host.send(1'h1, 0);
		apb(1'h0, ADDR_STATUS, 32'h0);
		chk("early trip", rd[ST_TRIP], 1'h0);
		u_host.send(1'h1, 3);
		chk("fault out", fout, 1'h1);
		chk("coast", coast, 1'h1);
		chk("display", disp, TRIP_CODE);
		apb(1'h0, ADDR_HIST, 32'h0);
		chk("history", rd, TRIP_CODE);
		u_host.send(1'h0, 0);
		apb(1'h0, ADDR_STATUS, 32'h0);
		chk("mode 0 held", rd[ST_TRIP], 1'h1);
		apb(1'h1, ADDR_CTRL, 32'h1);
		apb(1'h0, ADDR_STATUS, 32'h0);
		chk("cleared", rd[ST_TRIP], 1'h0);
	endtask : t_retry

	task automatic t_modbus();
		modbus <= 1'h1;
		repeat (3) u_host.send(1'h1, 0);
		apb(1'h0, ADDR_STATUS, 32'h0);
		chk("modbus trip", rd[ST_TRIP], 1'h0);
		modbus <= 1'h0;
		u_host.send(1'h0, 0);
	endtask : t_modbus

	task automatic t_alarm();
		apb(1'h1, ADDR_RETRY, SET_DISABLED);
		apb(1'h1, ADDR_TERMSEL, TERM_ALARM_HI);
		repeat (3) u_host.send(1'h1, 0);
		apb(1'h0, ADDR_STATUS, 32'h0);
		chk("alarm", rd[ST_ALARM], 1'h1);
		chk("no trip", rd[ST_TRIP], 1'h0);
		chk("term high", aterm, 1'h1);
		apb(1'h1, ADDR_TERMSEL, TERM_ALARM_LO);
		repeat (2) @(posedge clk);
		chk("term low", aterm, 1'h0);
		u_host.send(1'h0, 3);
		chk("term idle", aterm, 1'h1);
		apb(1'h1, ADDR_RETRY, RETRY_RST);
	endtask : t_alarm

	task automatic t_lock();
		apb(1'h1, ADDR_USERGRP, 32'h5);
		apb(1'h1, ADDR_RETRY, 32'h7);
		apb(1'h0, ADDR_RETRY, 32'h0);
		chk("locked", rd, RETRY_RST);
		opt <= 1'h1;
		apb(1'h1, ADDR_RETRY, 32'h7);
		apb(1'h0, ADDR_RETRY, 32'h0);
		chk("option", rd, 32'h7);
		apb(1'h1, ADDR_USERGRP, 32'h0);
		opt <= 1'h0;
		apb(1'h1, ADDR_RETRY, RETRY_RST);
	endtask : t_lock

	// error cleared while still decelerating
	task automatic t_mode2();
		apb(1'h1, ADDR_STOPMODE, CFS_DECEL_RESTART);
		run <= 1'h1;
		spd <= 16'h1234;
		u_host.send(1'h1, 0);
		u_host.send(1'h1, 3);
		chk("decel", decel, 1'h1);
		chk("no fault out", fout, 1'h0);
		u_host.send(1'h0, 3);
		chk("restart", o_run, 1'h1);
		chk("speed", o_spd, 16'h1234);
		chk("display back", disp, NO_CODE);
		apb(1'h0, ADDR_HIST, 32'h0);
		chk("history kept", rd, TRIP_CODE);
		hrst <= 1'h1;
		repeat (3) @(posedge clk);
		chk("hard coast", coast, 1'h1);
		hrst <= 1'h0;
	endtask : t_mode2

	// mode 1: decelerate, fault output only once stopped
	task automatic t_mode1();
		apb(1'h1, ADDR_STOPMODE, CFS_DECEL_ALM);
		u_host.send(1'h1, 0);
		u_host.send(1'h1, 3);
		chk("m1 decel", decel, 1'h1);
		chk("m1 early out", fout, 1'h0);
		stopd <= 1'h1;
		repeat (4) @(posedge clk);
		chk("m1 fault out", fout, 1'h1);
		chk("m1 display", disp, TRIP_CODE);
		chk("m1 coast", coast, 1'h0);
		u_host.send(1'h0, 0);
		apb(1'h0, ADDR_STATUS, 32'h0);
		chk("m1 held", rd[ST_TRIP], 1'h1);
		apb(1'h1, ADDR_CTRL, 32'h1);
		stopd <= 1'h0;
		apb(1'h0, ADDR_STATUS, 32'h0);
		chk("m1 cleared", rd[ST_FAULT], 1'h0);
	endtask : t_mode1

	task automatic t_net();
		apb(1'h1, ADDR_STOPMODE, CFS_COAST);
		apb(1'h1, ADDR_TIMEOUT, SET_DISABLED);
		net <= 1'h1;
		apb(1'h0, ADDR_STATUS, 32'h0);
		chk("check off", rd[ST_TRIP], 1'h0);
		net <= 1'h0;
		apb(1'h1, ADDR_TIMEOUT, TIMEOUT_RST);
		net <= 1'h1;
		apb(1'h0, ADDR_STATUS, 32'h0);
		chk("net trip", rd[ST_TRIP], 1'h1);
	endtask : t_net

	// main sequence
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		t_reset();
		t_retry();
		t_modbus();
		t_alarm();
		t_lock();
		t_mode2();
		t_mode1();
		t_net();
		end_sim();
	end
endmodule : tb
`default_nettype wire
